// [cprs_sequencer.sv]
// power-down / reset sequencer with mono feedthrough select and register slave
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "cprs_params.svh"
module cprs_sequencer
  import cprs_pkg::*;
#(
  parameter int ADDR_W     = 8,
  parameter int PD_CYCLES  = `CPRS_PD_US * `CPRS_CLK_MHZ,
  parameter int PU_CYCLES  = `CPRS_PU_US * `CPRS_CLK_MHZ,
  parameter int CAL_CYCLES = `CPRS_CAL_US * `CPRS_CLK_MHZ
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              quiet_power_down_n,
  input  wire logic              hard_reset_n,
  input  wire logic              mono_feedthrough_select,
  output cprs_route_t            mono_route,
  output cprs_power_t            power_ctl,
  output logic                   crystal_drive_out,
  output logic                   irq
);

  logic [1:0]        pd_sync;
  logic [1:0]        ft_sync;
  logic [1:0]        rst_sync;
  logic              core_rst;
  logic              pd_req;
  cprs_state_t       state;
  cprs_state_t       next_state;
  logic [31:0]       cnt;
  logic              cnt_done;
  logic              init_flag;
  logic [15:0]       mono_reg;
  logic              mix_pd;
  logic [1:0]        irq_stat;
  logic [1:0]        irq_mask;
  logic [1:0]        ev;
  logic              mixer_down;
  logic              aw_hold;
  logic              w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_go;
  logic              aw_take;
  logic              w_take;
  logic              ar_take;
  logic              wr_hit;
  logic [31:0]       rd_val;
  logic              rd_hit;

  // power-down and select pins pass two flops before any logic reads them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_sync <= 2'h0;
      ft_sync <= 2'h0;
    end else begin
      pd_sync <= {pd_sync[0], quiet_power_down_n};
      ft_sync <= {ft_sync[0], mono_feedthrough_select};
    end
  end

  // reset pin clears at once, release is synchronised to avoid a runt edge
  always_ff @(posedge aclk or negedge hard_reset_n) begin
    if (!hard_reset_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign core_rst = !aresetn || !rst_sync[1];
  assign pd_req   = !pd_sync[1];
  assign cnt_done = (cnt == 32'h0);

  // sequence choice; running sequences are cut short only by a reset
  always_comb begin
    next_state = state;
    case (state)
      CPRS_OFF: begin
        if (!pd_req) next_state = CPRS_UP;
      end
      CPRS_UP: begin
        if (cnt_done) next_state = CPRS_CAL;
      end
      CPRS_CAL: begin
        if (cnt_done) next_state = pd_req ? CPRS_DOWN : CPRS_ON;
      end
      CPRS_ON: begin
        if (pd_req) next_state = CPRS_DOWN;
      end
      CPRS_DOWN: begin
        if (cnt_done) next_state = CPRS_OFF;
      end
      default: next_state = CPRS_OFF;
    endcase
  end

  // state and interval counter; reset pin drops straight to off, no ramp
  always_ff @(posedge aclk or negedge hard_reset_n) begin
    if (!hard_reset_n) begin
      state <= CPRS_OFF;
      cnt   <= 32'h0;
    end else if (core_rst) begin
      state <= CPRS_OFF;
      cnt   <= 32'h0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        case (next_state)
          CPRS_UP:   cnt <= PU_CYCLES - 1;
          CPRS_CAL:  cnt <= CAL_CYCLES - 1;
          CPRS_DOWN: cnt <= PD_CYCLES - 1;
          default:   cnt <= 32'h0;
        endcase
      end else if (!cnt_done) begin
        cnt <= cnt - 32'h1;
      end
    end
  end

  // completion flag: set at the end of power-down, cleared on power-up
  always_ff @(posedge aclk or negedge hard_reset_n) begin
    if (!hard_reset_n) begin
      init_flag <= 1'b1;
    end else if (core_rst) begin
      init_flag <= 1'b1;
    end else if (state == CPRS_DOWN && next_state == CPRS_OFF) begin
      init_flag <= 1'b1;
    end else if (state == CPRS_OFF && next_state == CPRS_UP) begin
      init_flag <= 1'b0;
    end
  end

  // sequence events for the interrupt
  assign ev[`CPRS_IRQ_DOWN_BIT] = (state == CPRS_DOWN) && cnt_done;
  assign ev[`CPRS_IRQ_UP_BIT]   = (state == CPRS_CAL) && cnt_done && !pd_req;

  // bus handshake bookkeeping
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign wr_go   = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_hit  = (aw_addr == `CPRS_OFF_STATUS) || (aw_addr == `CPRS_OFF_MONO) ||
                   (aw_addr == `CPRS_OFF_CFG) || (aw_addr == `CPRS_OFF_IRQ_STAT) ||
                   (aw_addr == `CPRS_OFF_IRQ_MASK);

  // control registers: held at defaults while any power-down is requested
  always_ff @(posedge aclk or negedge hard_reset_n) begin
    if (!hard_reset_n) begin
      mono_reg <= `CPRS_MONO_RST;
      mix_pd   <= `CPRS_CFG_RST;
    end else if (core_rst || pd_req) begin
      mono_reg <= `CPRS_MONO_RST;
      mix_pd   <= `CPRS_CFG_RST;
    end else if (wr_go) begin
      if (aw_addr == `CPRS_OFF_MONO) begin
        if (w_strb[0]) mono_reg[7:0]  <= w_data[7:0];
        if (w_strb[1]) mono_reg[15:8] <= w_data[15:8];
      end
      if (aw_addr == `CPRS_OFF_CFG && w_strb[0]) mix_pd <= w_data[`CPRS_MIX_PD_BIT];
    end
  end

  // interrupt status and mask survive power-down so completion is seen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 2'h0;
      irq_mask <= `CPRS_MASK_RST;
    end else begin
      // a new event wins over a write-one clear in the same cycle
      if (wr_go && aw_addr == `CPRS_OFF_IRQ_STAT && w_strb[0]) begin
        irq_stat <= (irq_stat & ~w_data[1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      if (wr_go && aw_addr == `CPRS_OFF_IRQ_MASK && w_strb[0]) irq_mask <= w_data[1:0];
    end
  end

  // write channel: address and data taken in either order, one at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CPRS_RESP_OK;
    end else begin
      s_axi_awready <= !aw_hold && !aw_take && !s_axi_bvalid && !wr_go;
      s_axi_wready  <= !w_hold && !w_take && !s_axi_bvalid && !wr_go;
      if (aw_take) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `CPRS_RESP_OK : `CPRS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read decode; unmapped addresses read zero with an error response
  always_comb begin
    rd_val = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `CPRS_OFF_STATUS: begin
        rd_val[`CPRS_INIT_BIT] = init_flag;
        rd_val[2:0]            = state;
      end
      `CPRS_OFF_MONO:     rd_val[15:0]             = mono_reg;
      `CPRS_OFF_CFG:      rd_val[`CPRS_MIX_PD_BIT] = mix_pd;
      `CPRS_OFF_IRQ_STAT: rd_val[1:0]              = irq_stat;
      `CPRS_OFF_IRQ_MASK: rd_val[1:0]              = irq_mask;
      default:            rd_hit                   = 1'b0;
    endcase
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `CPRS_RESP_OK;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? `CPRS_RESP_OK : `CPRS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // mixer counts as down whenever the core is not fully up
  assign mixer_down = (state != CPRS_ON) || mix_pd;

  // analog routing and power levels, all from flops
  always_ff @(posedge aclk or negedge hard_reset_n) begin
    if (!hard_reset_n) begin
      mono_route        <= '0;
      power_ctl         <= '0;
      crystal_drive_out <= 1'b1;
    end else if (core_rst) begin
      mono_route        <= '0;
      power_ctl         <= '0;
      crystal_drive_out <= 1'b1;
    end else begin
      if (mixer_down) begin
        // select is taken as is; changing it here may click, which is the user's call
        mono_route.mono_out_en <= ft_sync[1];
        mono_route.line1_en    <= 1'b0;
      end else begin
        mono_route.mono_out_en <= !mono_reg[`CPRS_MONO_IN_BIT] && !mono_reg[`CPRS_MONO_OUT_BIT];
        mono_route.line1_en    <= !mono_reg[`CPRS_MONO_IN_BIT];
      end
      power_ctl.analog_on   <= (next_state != CPRS_OFF);
      power_ctl.calibrating <= (next_state == CPRS_CAL);
      power_ctl.mixer_on    <= (next_state == CPRS_ON) && !mix_pd;
      // oscillator keeps running through the whole power-down interval
      crystal_drive_out     <= (next_state != CPRS_OFF) || !pd_req;
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat | ev) & irq_mask);
    end
  end

endmodule : cprs_sequencer

// [cprs_params.svh]
// offsets, field positions, reset values and timing figures of the sequencer
`ifndef CPRS_PARAMS_SVH
`define CPRS_PARAMS_SVH
`define CPRS_OFF_STATUS    8'h00
`define CPRS_OFF_MONO      8'h08
`define CPRS_OFF_CFG       8'h10
`define CPRS_OFF_IRQ_STAT  8'h14
`define CPRS_OFF_IRQ_MASK  8'h18
`define CPRS_INIT_BIT      15
`define CPRS_MONO_IN_BIT   15
`define CPRS_MONO_OUT_BIT  6
`define CPRS_MIX_PD_BIT    0
`define CPRS_IRQ_DOWN_BIT  0
`define CPRS_IRQ_UP_BIT    1
`define CPRS_MONO_RST      16'h8040
`define CPRS_CFG_RST       1'b0
`define CPRS_MASK_RST      2'h0
`define CPRS_CLK_MHZ       125
`define CPRS_PD_US         5000
`define CPRS_PU_US         470000
`define CPRS_CAL_US        4000
`define CPRS_RESP_OK       2'h0
`define CPRS_RESP_SLVERR   2'h2
`endif

// [cprs_pkg.sv]
// types shared by the power and reset sequencer
package cprs_pkg;
  // power sequence states
  typedef enum logic [2:0] {
    CPRS_OFF,
    CPRS_UP,
    CPRS_CAL,
    CPRS_ON,
    CPRS_DOWN
  } cprs_state_t;

  // mono input routing to the analog outputs
  typedef struct packed {
    logic mono_out_en;
    logic line1_en;
  } cprs_route_t;

  // power control levels towards the analog core
  typedef struct packed {
    logic analog_on;
    logic calibrating;
    logic mixer_on;
  } cprs_power_t;
endpackage : cprs_pkg

// [cprs_sequencer_chk.sv]
// assertion checker for the power and reset sequencer
`timescale 1ns/1ps
`include "cprs_params.svh"
module cprs_sequencer_chk
  import cprs_pkg::*;
#(parameter int PD_CYCLES = `CPRS_PD_US * `CPRS_CLK_MHZ) (
  input wire logic  aclk,
  input wire logic  aresetn,
  input wire logic  s_axi_arvalid,
  input wire logic  s_axi_arready,
  input wire logic  s_axi_rvalid,
  input wire logic  s_axi_rready,
  input wire logic  s_axi_bvalid,
  input wire logic  s_axi_bready,
  input wire logic  quiet_power_down_n,
  input wire logic  hard_reset_n,
  input wire logic  mono_feedthrough_select,
  input cprs_route_t mono_route,
  input cprs_power_t power_ctl,
  input wire logic  crystal_drive_out
);
  localparam int PD_HI = PD_CYCLES + 8;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int unsigned low_cnt;
  logic        armed;
  // age of a quiet power-down request; armed only when it arrived with the mixer up
  always_ff @(posedge aclk) begin
    if (!aresetn || !hard_reset_n || quiet_power_down_n) begin
      low_cnt <= 0;
      armed   <= 1'h0;
    end else begin
      low_cnt <= low_cnt + 1;
      if (low_cnt == 0) armed <= power_ctl.mixer_on;
    end
  end
  sequence s_released;
    $rose(hard_reset_n) ##1 quiet_power_down_n [*3];
  endsequence
  sequence s_powering;
    power_ctl.analog_on && !power_ctl.mixer_on;
  endsequence
  a_hard_off: assert property (!hard_reset_n |-> power_ctl == '0 && mono_route == '0)
    else $error("hard reset left outputs active");
  a_route_feed: assert property ((!power_ctl.mixer_on && hard_reset_n && $stable(mono_feedthrough_select)) [*6]
    |-> mono_route == {mono_feedthrough_select, 1'h0})
    else $error("feedthrough routing wrong");
  a_pd_early: assert property (armed && low_cnt < PD_CYCLES |-> crystal_drive_out)
    else $error("power-down finished early");
  // counted on the request's age, since the real interval is far beyond any delay range
  a_pd_done: assert property (armed && low_cnt == PD_HI |-> !crystal_drive_out)
    else $error("power-down not finished in time");
  a_wake_up: assert property (s_released |-> ##[1:8] s_powering)
    else $error("power-up did not start");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule : cprs_sequencer_chk
bind cprs_sequencer cprs_sequencer_chk #(.PD_CYCLES(PD_CYCLES)) u_chk (.aclk, .aresetn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .quiet_power_down_n,
  .hard_reset_n, .mono_feedthrough_select, .mono_route, .power_ctl, .crystal_drive_out);

// [cprs_host_model.sv]
// host model driving the power-down, reset and feedthrough select pins
`timescale 1ns/1ps
module cprs_host_model (
  input  wire logic aclk,
  input  wire logic want_pd,
  input  wire logic want_rst,
  input  wire logic want_sel,
  input  wire logic mixer_on,
  output logic      quiet_power_down_n = 1'h1,
  output logic      hard_reset_n = 1'h1,
  output logic      mono_feedthrough_select = 1'h0
);
  // pins move just after an edge; aclk keeps running through every sequence
  always @(posedge aclk) begin
    quiet_power_down_n <= !want_pd;
    hard_reset_n       <= !want_rst;
  end
  // select only moves with the mixer up, since a change in power-down clicks
  always @(posedge aclk) begin
    if (mixer_on) mono_feedthrough_select <= want_sel;
  end
endmodule : cprs_host_model

// [cprs_sequencer_bench.sv]
// self-checking bench for the power and reset sequencer
`timescale 1ns/1ps
module cprs_sequencer_bench;
  import cprs_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0, want_pd = 1'h1, want_rst = 1'h0, want_sel = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        quiet_power_down_n, hard_reset_n, mono_feedthrough_select, crystal_drive_out, irq;
  cprs_route_t mono_route;
  cprs_power_t power_ctl;
  int          errors = 0, checks = 0;
  always #4 aclk = ~aclk;
  cprs_sequencer #(.PD_CYCLES(20), .PU_CYCLES(40), .CAL_CYCLES(10)) u_cprs_sequencer (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .quiet_power_down_n, .hard_reset_n, .mono_feedthrough_select,
    .mono_route, .power_ctl, .crystal_drive_out, .irq);
  cprs_host_model u_cprs_host_model (.aclk, .want_pd, .want_rst, .want_sel, .mixer_on(power_ctl.mixer_on),
    .quiet_power_down_n, .hard_reset_n, .mono_feedthrough_select);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // address and data go out together; each is dropped on its own take
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'h0;
    w = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  // poll the state field, bounded so a stuck sequence cannot hang the run
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    d = '1;
    while (d[2:0] !== s && n < 300) begin
      rd(8'h00);
      n++;
    end
    chk("state", {29'h0, s}, {29'h0, d[2:0]});
  endtask : wait_st
  // power-down is held through reset, so the device must sit in off until it is released
  task automatic t_boot;
    wait_st(3'h0);
    chk("init_rst", 32'h1, {31'h0, d[15]});
    chk("boot_xtal", 32'h0, {31'h0, crystal_drive_out});
    want_pd <= 1'h0;
    wait_st(3'h3);
    chk("init_up", 32'h0, {31'h0, d[15]});
    chk("on_power", 32'hd, {28'h0, crystal_drive_out, power_ctl});
    rd(8'h08);
    chk("mono_rst", 32'h8040, d);
    rd(8'h14);
    chk("irq_stat", 32'h2, d & 32'h3);
    chk("irq_mask", 32'h0, {31'h0, irq});
    wr(8'h18, 32'h3);
    repeat (3) @(posedge aclk);
    chk("irq_set", 32'h1, {31'h0, irq});
    wr(8'h14, 32'h3);
    wr(8'h18, 32'h1);
    repeat (3) @(posedge aclk);
    chk("irq_w1c", 32'h0, {31'h0, irq});
    rd(8'h40);
    chk("bad_rd", 32'h2, d | {30'h0, r});
    wr(8'h40, 32'h5);
    chk("bad_wr", 32'h2, {30'h0, r});
  endtask : t_boot
  task automatic t_route;
    wr(8'h08, 32'h0);
    repeat (4) @(posedge aclk);
    chk("route_on", 32'h3, {30'h0, mono_route});
    wr(8'h10, 32'h1);
    repeat (4) @(posedge aclk);
    chk("route_mute", 32'h0, {30'h0, mono_route});
    wr(8'h10, 32'h0);
    want_sel <= 1'h1;
    repeat (8) @(posedge aclk);
    wr(8'h10, 32'h1);
    repeat (4) @(posedge aclk);
    chk("route_feed", 32'h2, {30'h0, mono_route});
    wr(8'h10, 32'h0);
  endtask : t_route
  task automatic t_pd;
    want_pd <= 1'h1;
    wait_st(3'h0);
    chk("pd_flag", 32'h1, {31'h0, d[15]});
    chk("pd_power", 32'h0, {29'h0, power_ctl});
    chk("pd_xtal", 32'h0, {31'h0, crystal_drive_out});
    rd(8'h08);
    chk("pd_mono", 32'h8040, d);
    chk("irq_down", 32'h1, {31'h0, irq});
    wr(8'h14, 32'h1);
    repeat (3) @(posedge aclk);
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask : t_pd
  // power-down asked in mid power-up: calibration still runs first
  task automatic t_mid;
    want_pd <= 1'h0;
    wait_st(3'h1);
    want_pd <= 1'h1;
    wait_st(3'h2);
    wait_st(3'h0);
    want_pd <= 1'h0;
    wait_st(3'h3);
  endtask : t_mid
  task automatic t_hard;
    wr(8'h08, 32'h0);
    want_rst <= 1'h1;
    repeat (2) @(posedge aclk);
    #1;
    chk("hard_pwr", 32'h0, {29'h0, power_ctl});
    rd(8'h00);
    chk("hard_flag", 32'h1, {31'h0, d[15]});
    want_rst <= 1'h0;
    wait_st(3'h3);
    rd(8'h08);
    chk("hard_mono", 32'h8040, d);
  endtask : t_hard
  task automatic tally_and_finish;
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_boot();
    t_route();
    t_pd();
    t_mid();
    t_hard();
    tally_and_finish();
  end
  // the whole sequence needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    tally_and_finish();
  end
endmodule : cprs_sequencer_bench
